//--- verilog/dis_pkg.sv
package dis_pkg;
   // ==========================================
   // Register map
   localparam logic [7:0]  ADDR_DATA       = 8'hB2;
   localparam logic [7:0]  ADDR_CTRL       = 8'hB3;
   localparam logic [7:0]  ADDR_STAT       = 8'hB4;
   localparam int          DATA_W          = 16;
   localparam int          STAT_W          = 8;
   localparam int          NUM_CH          = 2;
   // ==========================================
   // Divider widths and reset values
   localparam int          N_W             = 20;
   localparam int          R_W             = 13;
   localparam logic [19:0] N_RESET         = 20'h00001;
   localparam logic [12:0] R_RESET         = 13'h0001;
   // ==========================================
   // Divider data word layout
   localparam int          DATA_CH_BIT     = 15;
   localparam int          DATA_SET_BIT    = 14;
   localparam int          DATA_IDX_HI     = 13;
   localparam int          DATA_IDX_LO     = 12;
   localparam int          PAYLOAD_W       = 12;
   localparam int          N_HI_W          = 8;
   localparam logic [1:0]  WORD_N_LO       = 2'h0;
   localparam logic [1:0]  WORD_N_HI       = 2'h1;
   localparam logic [1:0]  WORD_R_LO       = 2'h2;
   localparam logic [1:0]  WORD_R_HI       = 2'h3;
   // ==========================================
   // Control word layout, one byte per channel
   localparam int          CTRL_STRIDE     = 8;
   localparam int          CTRL_EN         = 0;
   localparam int          CTRL_SET        = 1;
   localparam int          CTRL_TOL4       = 2;
   localparam int          CTRL_GAIN       = 3;
   localparam int          CTRL_LOST_MASK  = 4;
   localparam int          CTRL_LOCK_MASK  = 5;
   localparam int          CTRL_PSAVE      = 6;
   localparam int          CTRL_REF_PIN    = 15;
   localparam logic [15:0] CTRL_RESET      = 16'h0000;
   // ==========================================
   // Status layout and lock tolerance
   localparam int          STAT_LOCK_BASE  = 0;
   localparam int          STAT_LOST_BASE  = 2;
   localparam int          ERR_W           = 3;
   localparam logic [2:0]  TOL_ONE         = 3'h1;
   localparam logic [2:0]  TOL_FOUR        = 3'h4;
   localparam logic [2:0]  ERR_MAX         = 3'h7;
endpackage

//--- verilog/dis_synth_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Two independent channels with own divider sets, status and pump, one shared reference.
// - One reference select chooses crystal clock or reference pin for both channels.
// - Feedback divider is 20 bits wide, reference divider 13 bits wide.
// - Both dividers bring reference and VCO down to the same comparison rate.
// - Phase-frequency detector per channel drives a three-state charge pump output.
// - Gain bit at control bit 3 or 11 selects high or low pump current.
// - Each channel holds two divider sets; control selects the active one.
// - Four data writes load a set; partial values act until the last.
// - Lock tolerance is one or four undivided reference cycles.
// - Lock is majority of last three measurements held in a shift register.
// - Lock bits readable in 8-bit status register, each maskable onto interrupt.
// - Locked to out-of-lock transition is a sticky event that can interrupt.
module dis_synth_ctrl (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        xtal_clock_in,
   input  wire logic        synth_reference_clock_pin,
   input  wire logic        vco_in_one,
   input  wire logic        vco_in_two,
   output logic             pump_output_channel_one,
   output logic             pump_oe_n_channel_one,
   output logic             pump_gain_high_one,
   output logic             pump_output_channel_two,
   output logic             pump_oe_n_channel_two,
   output logic             pump_gain_high_two,
   output logic             host_irq
);
   // ==========================================
   // Shared state
   logic [2:0]  xtal_sync_reg;
   logic [2:0]  xtal_sync_next;
   logic [2:0]  pin_sync_reg;
   logic [2:0]  pin_sync_next;
   logic [2:0]  vco_sync_reg  [dis_pkg::NUM_CH];
   logic [2:0]  vco_sync_next [dis_pkg::NUM_CH];
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic [19:0] n_reg  [2 * dis_pkg::NUM_CH];
   logic [19:0] n_next [2 * dis_pkg::NUM_CH];
   logic [12:0] r_reg  [2 * dis_pkg::NUM_CH];
   logic [12:0] r_next [2 * dis_pkg::NUM_CH];
   logic [1:0]  lost_reg;
   logic [1:0]  lost_next;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;
   logic        irq_reg;
   logic        irq_next;
   logic [1:0]  lock_reg;
   logic [1:0]  lost_evt;
   logic        ref_tick;
   logic [7:0]  status;

   // ==========================================
   // Reference select and status word
   always_comb begin
      ref_tick = ctrl_reg[dis_pkg::CTRL_REF_PIN] ? (pin_sync_reg[1] & ~pin_sync_reg[2])
                                                 : (xtal_sync_reg[1] & ~xtal_sync_reg[2]);
      status = '0;
      status[dis_pkg::STAT_LOCK_BASE +: dis_pkg::NUM_CH] = lock_reg;
      status[dis_pkg::STAT_LOST_BASE +: dis_pkg::NUM_CH] = lost_reg;
   end

   // ==========================================
   // Input synchronisers
   // Only later stages are read, so a metastable first stage never reaches logic
   always_comb begin
      xtal_sync_next   = {xtal_sync_reg[1:0], xtal_clock_in};
      pin_sync_next    = {pin_sync_reg[1:0], synth_reference_clock_pin};
      vco_sync_next[0] = {vco_sync_reg[0][1:0], vco_in_one};
      vco_sync_next[1] = {vco_sync_reg[1][1:0], vco_in_two};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         xtal_sync_reg   <= '0;
         pin_sync_reg    <= '0;
         vco_sync_reg[0] <= '0;
         vco_sync_reg[1] <= '0;
      end else if (ce) begin
         xtal_sync_reg <= xtal_sync_next;
         pin_sync_reg  <= pin_sync_next;
         vco_sync_reg  <= vco_sync_next;
      end
   end

   // ==========================================
   // Control and divider registers
   always_comb begin
      logic [1:0] sidx;
      sidx = {reg_wdata[dis_pkg::DATA_CH_BIT], reg_wdata[dis_pkg::DATA_SET_BIT]};
      ctrl_next = ctrl_reg;
      n_next = n_reg;
      r_next = r_reg;
      if (reg_wr && reg_addr == dis_pkg::ADDR_CTRL) begin
         ctrl_next = reg_wdata;
      end
      // Each word takes effect at once, so a live set glitches while loading
      if (reg_wr && reg_addr == dis_pkg::ADDR_DATA) begin
         unique case (reg_wdata[dis_pkg::DATA_IDX_HI:dis_pkg::DATA_IDX_LO])
            dis_pkg::WORD_N_LO: n_next[sidx][dis_pkg::PAYLOAD_W-1:0] = reg_wdata[dis_pkg::PAYLOAD_W-1:0];
            dis_pkg::WORD_N_HI: n_next[sidx][dis_pkg::N_W-1:dis_pkg::PAYLOAD_W] =
                                   reg_wdata[dis_pkg::N_HI_W-1:0];
            dis_pkg::WORD_R_LO: r_next[sidx][dis_pkg::PAYLOAD_W-1:0] = reg_wdata[dis_pkg::PAYLOAD_W-1:0];
            dis_pkg::WORD_R_HI: r_next[sidx][dis_pkg::R_W-1] = reg_wdata[0];
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= dis_pkg::CTRL_RESET;
         for (int i = 0; i < 2 * dis_pkg::NUM_CH; i++) begin
            n_reg[i] <= dis_pkg::N_RESET;
            r_reg[i] <= dis_pkg::R_RESET;
         end
      end else if (ce) begin
         ctrl_reg <= ctrl_next;
         n_reg    <= n_next;
         r_reg    <= r_next;
      end
   end

   // ==========================================
   // Status, read data and interrupt
   always_comb begin
      // A new loss event in the read cycle survives the clear
      rdata_next = rdata_reg;
      lost_next  = lost_reg | lost_evt;
      if (reg_rd && reg_addr == dis_pkg::ADDR_STAT) begin
         rdata_next = status;
         lost_next  = lost_evt;
      end else if (reg_rd) begin
         rdata_next = '0;
      end
      irq_next = 1'b0;
      for (int c = 0; c < dis_pkg::NUM_CH; c++) begin
         irq_next = irq_next
                  | (lost_reg[c] & ctrl_reg[c*dis_pkg::CTRL_STRIDE + dis_pkg::CTRL_LOST_MASK])
                  | (lock_reg[c] & ctrl_reg[c*dis_pkg::CTRL_STRIDE + dis_pkg::CTRL_LOCK_MASK]);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lost_reg  <= '0;
         rdata_reg <= '0;
         irq_reg   <= 1'b0;
      end else if (ce) begin
         lost_reg  <= lost_next;
         rdata_reg <= rdata_next;
         irq_reg   <= irq_next;
      end
   end

   // ==========================================
   // Channel loops
   logic [1:0]  pump_out_reg;
   logic [1:0]  pump_oe_n_reg;
   logic [1:0]  gain_reg;

   for (genvar c = 0; c < dis_pkg::NUM_CH; c++) begin : g_ch
      logic [12:0] rc_reg;
      logic [12:0] rc_next;
      logic [19:0] fc_reg;
      logic [19:0] fc_next;
      logic        up_reg;
      logic        up_next;
      logic        dn_reg;
      logic        dn_next;
      logic [2:0]  err_reg;
      logic [2:0]  err_next;
      logic [2:0]  hist_reg;
      logic [2:0]  hist_next;
      logic        lock_next;
      logic        out_next;
      logic        oe_n_next;
      logic        gain_next;
      logic        active;
      logic        set_sel;
      logic        vco_tick;
      logic [19:0] n_div;
      logic [12:0] r_div;
      logic [2:0]  tol;

      // ==========================================
      // Dividers, phase detector, lock history and pump
      always_comb begin
         logic ref_pulse;
         logic fb_pulse;
         ref_pulse = 1'b0;
         fb_pulse  = 1'b0;
         active  = ctrl_reg[c*dis_pkg::CTRL_STRIDE + dis_pkg::CTRL_EN]
                 & ~ctrl_reg[c*dis_pkg::CTRL_STRIDE + dis_pkg::CTRL_PSAVE];
         set_sel = ctrl_reg[c*dis_pkg::CTRL_STRIDE + dis_pkg::CTRL_SET];
         n_div   = n_reg[{(c != 0), set_sel}];
         r_div   = r_reg[{(c != 0), set_sel}];
         tol     = ctrl_reg[c*dis_pkg::CTRL_STRIDE + dis_pkg::CTRL_TOL4] ? dis_pkg::TOL_FOUR
                                                                         : dis_pkg::TOL_ONE;
         vco_tick = vco_sync_reg[c][1] & ~vco_sync_reg[c][2];
         gain_next = ctrl_reg[c*dis_pkg::CTRL_STRIDE + dis_pkg::CTRL_GAIN];
         rc_next = rc_reg;
         fc_next = fc_reg;
         up_next = up_reg;
         dn_next = dn_reg;
         err_next  = err_reg;
         hist_next = hist_reg;
         lock_next = lock_reg[c];
         if (!active) begin
            rc_next = '0;
            fc_next = '0;
            up_next = 1'b0;
            dn_next = 1'b0;
            err_next  = '0;
            hist_next = '0;
            lock_next = 1'b0;
         end else begin
            // Divide by zero behaves as divide by one
            if (ref_tick) begin
               if (r_div == '0 || rc_reg >= r_div - 13'h0001) begin
                  rc_next = '0;
                  ref_pulse = 1'b1;
               end else begin
                  rc_next = rc_reg + 13'h0001;
               end
            end
            if (vco_tick) begin
               if (n_div == '0 || fc_reg >= n_div - 20'h00001) begin
                  fc_next = '0;
                  fb_pulse = 1'b1;
               end else begin
                  fc_next = fc_reg + 20'h00001;
               end
            end
            // Phase error is counted in undivided reference edges
            if (ref_tick && (up_reg || dn_reg) && err_reg != dis_pkg::ERR_MAX) begin
               err_next = err_reg + 3'h1;
            end
            up_next = up_reg | ref_pulse;
            dn_next = dn_reg | fb_pulse;
            if (up_next && dn_next) begin
               up_next = 1'b0;
               dn_next = 1'b0;
               hist_next = {hist_reg[1:0], (err_next < tol)};
               err_next  = '0;
               lock_next = (hist_next[0] & hist_next[1]) | (hist_next[0] & hist_next[2])
                         | (hist_next[1] & hist_next[2]);
            end
         end
         out_next  = up_next;
         // Floating the pump lets the loop filter hold its charge between events
         oe_n_next = ~(up_next ^ dn_next);
         // Disabling a locked channel also counts as a loss
         lost_evt[c] = lock_reg[c] & ~lock_next;
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            rc_reg   <= '0;
            fc_reg   <= '0;
            up_reg   <= 1'b0;
            dn_reg   <= 1'b0;
            err_reg  <= '0;
            hist_reg <= '0;
            lock_reg[c]      <= 1'b0;
            pump_out_reg[c]  <= 1'b0;
            pump_oe_n_reg[c] <= 1'b1;
            gain_reg[c]      <= 1'b0;
         end else if (ce) begin
            rc_reg   <= rc_next;
            fc_reg   <= fc_next;
            up_reg   <= up_next;
            dn_reg   <= dn_next;
            err_reg  <= err_next;
            hist_reg <= hist_next;
            lock_reg[c]      <= lock_next;
            pump_out_reg[c]  <= out_next;
            pump_oe_n_reg[c] <= oe_n_next;
            gain_reg[c]      <= gain_next;
         end
      end
   end

   // ==========================================
   // Outputs
   assign reg_rdata               = rdata_reg;
   assign host_irq                = irq_reg;
   assign pump_output_channel_one = pump_out_reg[0];
   assign pump_oe_n_channel_one   = pump_oe_n_reg[0];
   assign pump_gain_high_one      = gain_reg[0];
   assign pump_output_channel_two = pump_out_reg[1];
   assign pump_oe_n_channel_two   = pump_oe_n_reg[1];
   assign pump_gain_high_two      = gain_reg[1];
endmodule // dis_synth_ctrl

//--- testbench/dis_synth_ctrl_properties.sv
`timescale 1ns/1ps
// ==========================================
// Port-level checks of the synthesiser control block
module dis_synth_ctrl_properties (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        pump_oe_n_channel_one,
   input wire logic        pump_oe_n_channel_two,
   input wire logic        pump_gain_high_one,
   input wire logic        pump_gain_high_two,
   input wire logic        host_irq
);
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic        ctrl_wr;
   logic        rd_stat;
   // Shadow of the control word, which cannot be read back
   assign ctrl_wr = ce && reg_wr && reg_addr == dis_pkg::ADDR_CTRL;
   assign rd_stat = ce && reg_rd && reg_addr == dis_pkg::ADDR_STAT;
   always_comb ctrl_next = ctrl_wr ? reg_wdata : ctrl_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) ctrl_reg <= dis_pkg::CTRL_RESET;
      else ctrl_reg <= ctrl_next;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_unmapped; ce && reg_rd && reg_addr != dis_pkg::ADDR_STAT |=> reg_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("non-status read not zero");
   property p_stat_top; rd_stat |=> reg_rdata[7:4] == 4'h0; endproperty
   a_stat_top: assert property (p_stat_top) else $error("status top bits set");
   property p_gain_one; ctrl_wr ##1 !ctrl_wr |=> pump_gain_high_one == $past(reg_wdata[3], 2); endproperty
   a_gain_one: assert property (p_gain_one) else $error("gain one not from bit 3");
   property p_gain_two; ctrl_wr ##1 !ctrl_wr |=> pump_gain_high_two == $past(reg_wdata[11], 2); endproperty
   a_gain_two: assert property (p_gain_two) else $error("gain two not from bit 11");
   property p_irq_masked; !(ctrl_reg[4] || ctrl_reg[5] || ctrl_reg[12] || ctrl_reg[13]) [*4] |-> !host_irq; endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq with all masks off");
   // Idle channels must float the pump so the loop filter holds its charge
   property p_hiz_one; !(ctrl_reg[0] && !ctrl_reg[6]) [*4] |-> pump_oe_n_channel_one; endproperty
   a_hiz_one: assert property (p_hiz_one) else $error("idle pump one driving");
   property p_hiz_two; !(ctrl_reg[8] && !ctrl_reg[14]) [*4] |-> pump_oe_n_channel_two; endproperty
   a_hiz_two: assert property (p_hiz_two) else $error("idle pump two driving");
   property p_early_lock; $rose(ctrl_reg[0] && !ctrl_reg[6]) ##[0:3] rd_stat |=> !reg_rdata[0]; endproperty
   a_early_lock: assert property (p_early_lock) else $error("lock before two measurements");
   c_lock: cover property (rd_stat ##1 reg_rdata[0]);
   c_irq: cover property ($rose(host_irq));
   c_drive: cover property (!pump_oe_n_channel_one);
endmodule // dis_synth_ctrl_properties
bind dis_synth_ctrl dis_synth_ctrl_properties dis_synth_ctrl_properties_i (
   .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pump_oe_n_channel_one(pump_oe_n_channel_one),
   .pump_oe_n_channel_two(pump_oe_n_channel_two), .pump_gain_high_one(pump_gain_high_one),
   .pump_gain_high_two(pump_gain_high_two), .host_irq(host_irq));

//--- testbench/dis_vco_model.sv
`timescale 1ns/1ps
// ==========================================
// External VCO and loop filter
module dis_vco_model (
   input  wire logic  clk,
   input  wire logic  rst,
   input  wire logic  ref_in,
   input  wire logic  slow,
   input  wire logic  pump_out,
   input  wire logic  pump_oe_n,
   output logic       vco_out,
   output logic [15:0] up_cycles,
   output logic [15:0] dn_cycles
);
   logic tracked = 1'b0;
   logic free_run = 1'b0;
   // Tracking VCO lags by 10 ns so the reference edge always leads
   always @(ref_in) tracked <= #10 ref_in;
   // Stuck VCO runs far below the rate the reference asks for
   always #50 free_run = ~free_run;
   assign vco_out = slow ? free_run : tracked;
   // Filter charge moves only while the pump drives
   always @(posedge clk) begin
      up_cycles <= rst ? 16'h0000 : up_cycles + 16'(!pump_oe_n && pump_out);
      dn_cycles <= rst ? 16'h0000 : dn_cycles + 16'(!pump_oe_n && !pump_out);
   end
endmodule // dis_vco_model

//--- testbench/tb_dis_synth_ctrl.sv
`timescale 1ns/1ps
// ==========================================
// Bench for the dual synthesiser control block
module tb_dis_synth_ctrl;
   logic        clk;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        xtal = 1'b0;
   logic        pin = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic [7:0]  rdata, rv;
   logic [1:0]  vco;
   logic        out1, out2, oe1, oe2, g1, g2, irq;
   logic [31:0] ups, dns;
   int          errors = 0;
   int          checked = 0;
   int          cycles = 0;
   dis_synth_ctrl dis_synth_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(wdata), .reg_rd(reg_rd), .reg_rdata(rdata), .xtal_clock_in(xtal),
      .synth_reference_clock_pin(pin), .vco_in_one(vco[0]), .vco_in_two(vco[1]),
      .pump_output_channel_one(out1), .pump_oe_n_channel_one(oe1), .pump_gain_high_one(g1),
      .pump_output_channel_two(out2), .pump_oe_n_channel_two(oe2), .pump_gain_high_two(g2), .host_irq(irq));
   // Channel one tracks the reference, channel two is stuck slow
   dis_vco_model dis_vco_model_i [1:0] (.clk(clk), .rst(rst), .ref_in(xtal), .slow(2'h2),
      .pump_out({out2, out1}), .pump_oe_n({oe2, oe1}), .vco_out(vco), .up_cycles(ups), .dn_cycles(dns));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always #20 xtal = ~xtal;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         conclude();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rv = rdata;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic t_reset;
      logic [7:0] addrs [4];
      addrs = '{dis_pkg::ADDR_STAT, dis_pkg::ADDR_DATA, dis_pkg::ADDR_CTRL, 8'h00};
      foreach (addrs[i]) begin
         rd(addrs[i]);
         check("reset read", rv, 16'h0000);
      end
      check("pump one idle", oe1, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_lock;
      wr(dis_pkg::ADDR_CTRL, 16'h0109);
      tick(200);
      rd(dis_pkg::ADDR_STAT);
      check("lock tol one", rv, 16'h0001);
      check("gain one", g1, 1'b1);
      check("gain two", g2, 1'b0);
      check("slow vco pumped up", ups[31:16] > dns[31:16], 1'b1);
      wr(dis_pkg::ADDR_CTRL, 16'h0501);
      tick(200);
      rd(dis_pkg::ADDR_STAT);
      check("lock tol four", rv, 16'h0003);
      $display("test lock done");
   endtask
   task automatic t_lost;
      wr(dis_pkg::ADDR_CTRL, 16'h0510);
      tick(4);
      check("lost irq", irq, 1'b1);
      rd(dis_pkg::ADDR_STAT);
      check("lost status", rv, 16'h0006);
      tick(3);
      check("irq after read", irq, 1'b0);
      rd(dis_pkg::ADDR_STAT);
      check("lost cleared", rv, 16'h0002);
      $display("test lost done");
   endtask
   task automatic t_sets;
      wr(dis_pkg::ADDR_CTRL, 16'h0501);
      wr(dis_pkg::ADDR_DATA, 16'h4002);
      wr(dis_pkg::ADDR_DATA, 16'h5000);
      tick(200);
      rd(dis_pkg::ADDR_STAT);
      check("set zero kept", rv, 16'h0003);
      wr(dis_pkg::ADDR_CTRL, 16'h0503);
      tick(200);
      rd(dis_pkg::ADDR_STAT);
      check("partial set one", rv, 16'h0006);
      wr(dis_pkg::ADDR_CTRL, 16'h0500);
      wr(dis_pkg::ADDR_DATA, 16'h6002);
      wr(dis_pkg::ADDR_DATA, 16'h7000);
      wr(dis_pkg::ADDR_CTRL, 16'h0503);
      rd(dis_pkg::ADDR_STAT);
      check("no early lock", rv, 16'h0002);
      tick(200);
      rd(dis_pkg::ADDR_STAT);
      check("full set one", rv, 16'h0003);
      $display("test sets done");
   endtask
   task automatic t_ref;
      // Pin reference is held still, so a channel fed from it never gains lock; channel two keeps its earlier lock
      wr(dis_pkg::ADDR_CTRL, 16'h8500);
      wr(dis_pkg::ADDR_CTRL, 16'h8501);
      tick(200);
      rd(dis_pkg::ADDR_STAT);
      check("pin ref no lock", rv & 8'h05, 16'h0004);
      check("pump one down", out1, 1'b0);
      check("pump one drives", oe1, 1'b0);
      // Strobes are ignored while the clock enable is low
      @(posedge clk);
      ce <= 1'b0;
      wr(dis_pkg::ADDR_CTRL, 16'h0000);
      @(posedge clk);
      ce <= 1'b1;
      rd(dis_pkg::ADDR_STAT);
      check("frozen write", rv, 16'h0002);
      $display("test reference done");
   endtask
   task automatic conclude;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_lock();
      t_lost();
      t_sets();
      t_ref();
      conclude();
   end
endmodule // tb_dis_synth_ctrl
